// File: verilog/cmf_pkg.sv
// Constants shared by the message RAM event flag block.
// Assumes one 250 MHz clock and a plain register port.
package cmf_pkg;
   // ==========================================
   // Register port
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFS_STATUS = 8'h00;   // event_flags, read
   localparam logic [7:0] OFS_CLEAR = 8'h04;    // Write 1 to clear
   localparam logic [7:0] OFS_ENABLE = 8'h08;   // Interrupt enable
   localparam logic [7:0] OFS_CONFIG = 8'h0C;   // Control bits
   localparam logic [7:0] OFS_TS = 8'h10;       // Timestamp value
   localparam logic [7:0] OFS_TO_LIMIT = 8'h14; // Timeout reload
   localparam logic [7:0] OFS_RX_STATE = 8'h18; // Put index, state
   localparam logic [7:0] OFS_NEW_DATA = 8'h1C; // New-data bits
   // ==========================================
   // Flag field layout
   localparam int FLAG_LSB = 15;
   localparam int NFLAGS = 5;
   localparam int IDX_TEF_LOST = 0;  // Bit 15
   localparam int IDX_TS_WRAP = 1;   // Bit 16
   localparam int IDX_MRF = 2;       // Bit 17
   localparam int IDX_TIMEOUT = 3;   // Bit 18
   localparam int IDX_DED_RX = 4;    // Bit 19
   // ==========================================
   // Config register fields
   localparam int CFG_RESTRICT = 0;
   localparam int CFG_TS_EN = 1;
   localparam int CFG_TO_EN = 2;
   localparam int CFG_PRESC_LSB = 4;
   localparam int PRESC_W = 4;
   // ==========================================
   // Sizes and reset values
   localparam int NBUF = 4;
   localparam int BUF_W = 2;
   localparam int PUT_W = 3;
   localparam int TS_W = 16;
   localparam int TEF_SIZE_W = 6;
   localparam logic [15:0] TO_LIMIT_RST = 16'hFFFF;
   localparam logic [7:0] CFG_RST = 8'h00;
   typedef enum logic [1:0] {RX_IDLE, RX_FILTER, RX_STORE} cmf_rx_e;
endpackage : cmf_pkg

// File: verilog/cmf_flag_if.sv
// Interface between the top and the sticky flag bank.
// Assumes all members run on the top's clock.
`timescale 1ns/1ps
interface cmf_flag_if;
   import cmf_pkg::*;
   logic [NFLAGS-1:0] set;   // Event pulses
   logic [NFLAGS-1:0] clr;   // Host clear pulses
   logic [NFLAGS-1:0] en;    // Interrupt enables
   logic [NFLAGS-1:0] flags; // Sticky flags
   logic irq;                // Level interrupt
   modport ctl (output set, output clr, output en, input flags, input irq);
   modport bank (input set, input clr, input en, output flags, output irq);
endinterface : cmf_flag_if

// File: verilog/cmf_flag_bank.sv
// Sticky event flags with set-over-clear and interrupt gate.
// Assumes single-cycle set and clear pulses on clk.
`timescale 1ns/1ps
module cmf_flag_bank
   import cmf_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Flag traffic
   cmf_flag_if.bank fi
);
   logic [NFLAGS-1:0] flag_q; // Held flags
   logic [NFLAGS-1:0] next_flag; // Next flags

   // ==========================================
   // One sticky bit per event; set wins over clear
   genvar g;
   generate
      for (g = 0; g < NFLAGS; g++) begin : g_flag
         assign next_flag[g] = fi.set[g] | (flag_q[g] & ~fi.clr[g]); // [RQ13]
      end
   endgenerate

   // Flag storage
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) flag_q <= '0;
      else if (ce) flag_q <= next_flag;
   end

   assign fi.flags = flag_q;
   assign fi.irq = |(flag_q & fi.en);
endmodule : cmf_flag_bank

// File: verilog/cmf_rx_store.sv
// Receive handler storage tracker: filter, store, abort, commit.
// Assumes handler strobes are one-cycle pulses on clk.
`timescale 1ns/1ps
module cmf_rx_store
   import cmf_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Handler strobes
   input wire logic arb_next,
   input wire logic accept_ok,
   input wire logic reject,
   input wire logic to_ded,
   input wire logic [BUF_W-1:0] buf_idx,
   input wire logic store_done,
   input wire logic wr_fail,
   input wire logic [NBUF-1:0] nd_clr,
   // Results
   output logic mrf_evt,
   output logic ded_evt,
   output logic abort,
   output logic restart,
   output logic [PUT_W-1:0] put_idx,
   output logic [NBUF-1:0] new_data,
   output cmf_rx_e state
);
   logic tgt_ded; // Target is dedicated buffer
   logic [BUF_W-1:0] tgt_idx; // Target buffer
   logic late; // Arbitration overtook work
   logic fail; // Write refused
   logic commit; // Clean store end
   logic [NBUF-1:0] ded_set; // New-data set
   cmf_rx_e next_state;

   // ==========================================
   // Event decode
   assign late = arb_next && (state != RX_IDLE); // [RQ2]
   assign fail = wr_fail && (state == RX_STORE); // [RQ4]
   assign commit = store_done && (state == RX_STORE) && !late && !fail;
   assign abort = late | fail; // [RQ3] [RQ4]
   assign restart = late; // [RQ3]
   assign mrf_evt = abort; // [RQ2] [RQ4]
   assign ded_evt = commit && tgt_ded; // [RQ1]
   assign ded_set = ded_evt ? (NBUF'(1) << tgt_idx) : '0;

   // Next state; a late arrival restarts filtering
   always_comb begin
      next_state = state;
      unique case (state)
         RX_IDLE: if (arb_next) next_state = RX_FILTER;
         RX_FILTER: begin
            if (late) next_state = RX_FILTER; // [RQ3]
            else if (accept_ok) next_state = RX_STORE;
            else if (reject) next_state = RX_IDLE;
         end
         RX_STORE: begin
            if (late) next_state = RX_FILTER; // [RQ3]
            else if (fail || commit) next_state = RX_IDLE;
         end
      endcase
   end

   // State and target latch
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= RX_IDLE;
         tgt_ded <= 1'b0;
         tgt_idx <= '0;
      end else if (ce) begin
         state <= next_state;
         if (state == RX_FILTER && accept_ok) begin
            tgt_ded <= to_ded;
            tgt_idx <= buf_idx;
         end
      end
   end

   // Put index moves and new-data bits set only on commit; aborted slot is reused
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         put_idx <= '0;
         new_data <= '0;
      end else if (ce) begin
         if (commit && !tgt_ded) put_idx <= put_idx + PUT_W'(1); // [RQ5] [RQ6]
         new_data <= ded_set | (new_data & ~nd_clr); // [RQ5]
      end
   end
endmodule : cmf_rx_store

// File: verilog/cmf_event_top.sv
// Message RAM event flags: bits 19..15 of the event register.
// Assumes handler strobes from logic on clk; register port same clock.
//
// How it works
// [RQ1] Dedicated buffer store sets bit 19
// [RQ2] Late receive work sets bit 17
// [RQ3] Late work aborts, new message processed
// [RQ4] Receive write failure sets 17, aborts
// [RQ5] Abort keeps put index, no new-data
// [RQ6] Next store overwrites partial message
// [RQ7] Late transmit fetch sets 17, aborts
// [RQ8] Transmit failure enters restricted mode
// [RQ9] Host clears restricted bit to leave
// [RQ10] Timestamp wrap sets bit 16
// [RQ11] Lost event FIFO element sets 15
// [RQ12] Write to zero-size event FIFO sets 15
// [RQ13] Timeout sets 18; flags hold until cleared
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
module cmf_event_top
   import cmf_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   // Receive handler
   input wire logic rx_arb_next,
   input wire logic rx_accept_ok,
   input wire logic rx_reject,
   input wire logic rx_to_ded,
   input wire logic [BUF_W-1:0] rx_buf_idx,
   input wire logic rx_store_done,
   input wire logic rx_wr_fail,
   output logic rx_abort,
   output logic rx_restart,
   output logic [PUT_W-1:0] rx_put_idx,
   output logic [NBUF-1:0] rx_new_data,
   // Transmit handler
   input wire logic tx_fetch_late,
   output logic tx_abort,
   // Transmit event FIFO
   input wire logic tef_wr_try,
   input wire logic tef_full,
   input wire logic [TEF_SIZE_W-1:0] tef_size,
   // Status outputs
   output logic restricted_operation_bit,
   output logic [TS_W-1:0] ts_value,
   output logic irq
);
   // ==========================================
   // Address decode
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   wire wr_clear = wr && hit(addr, OFS_CLEAR);     // Clear strobe
   wire wr_enable = wr && hit(addr, OFS_ENABLE);   // Enable write
   wire wr_config = wr && hit(addr, OFS_CONFIG);   // Config write
   wire wr_limit = wr && hit(addr, OFS_TO_LIMIT);  // Timeout reload
   wire wr_newdata = wr && hit(addr, OFS_NEW_DATA); // New-data clear

   // ==========================================
   // Control registers
   logic [NFLAGS-1:0] int_en; // Interrupt enables
   logic ts_en; // Timestamp counter run
   logic to_en; // Timeout counter run
   logic [PRESC_W-1:0] ts_presc; // Timestamp prescale
   logic [15:0] to_limit; // Timeout reload value
   logic restrict_q; // Restricted operation

   // Flag bank link
   cmf_flag_if fl ();

   // Receive tracker results
   logic rx_mrf_evt; // Receive side failure
   logic rx_ded_evt; // Dedicated store done
   cmf_rx_e rx_state; // Tracker state

   // Transmit and event FIFO events
   wire tx_mrf_evt = tx_fetch_late; // [RQ7]
   wire tef_lost = tef_wr_try && (tef_full || (tef_size == '0)); // [RQ11] [RQ12]

   // Timestamp and timeout events
   logic ts_wrap; // Counter wrap pulse
   logic to_hit; // Timeout reached pulse

   // ==========================================
   // Config and enable registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         int_en <= '0;
         ts_en <= CFG_RST[CFG_TS_EN];
         to_en <= CFG_RST[CFG_TO_EN];
         ts_presc <= CFG_RST[CFG_PRESC_LSB +: PRESC_W];
      end else if (ce) begin
         if (wr_enable) int_en <= wdata[FLAG_LSB +: NFLAGS];
         if (wr_config) begin
            ts_en <= wdata[CFG_TS_EN];
            to_en <= wdata[CFG_TO_EN];
            ts_presc <= wdata[CFG_PRESC_LSB +: PRESC_W];
         end
      end
   end

   // Timeout reload register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) to_limit <= TO_LIMIT_RST;
      else if (ce && wr_limit) to_limit <= wdata[15:0];
   end

   // ==========================================
   // Restricted operation bit
   // Hardware set wins over a host write of zero in the same cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         restrict_q <= CFG_RST[CFG_RESTRICT];
      end else if (ce) begin
         if (tx_mrf_evt) restrict_q <= 1'b1; // [RQ8]
         else if (wr_config) restrict_q <= wdata[CFG_RESTRICT]; // [RQ9]
      end
   end

   assign restricted_operation_bit = restrict_q;
   assign tx_abort = tx_mrf_evt; // [RQ7]

   // ==========================================
   // Timestamp counter with prescaler
   logic [PRESC_W-1:0] presc_cnt; // Prescale divider
   logic [TS_W-1:0] ts_cnt; // Timestamp count
   wire presc_tick = ts_en && (presc_cnt == ts_presc); // Count step

   // Wrap pulse when the counter rolls over
   assign ts_wrap = presc_tick && (ts_cnt == {TS_W{1'b1}}); // [RQ10]

   // Divider and counter
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         presc_cnt <= '0;
         ts_cnt <= '0;
      end else if (ce) begin
         if (!ts_en || presc_tick) presc_cnt <= '0;
         else presc_cnt <= presc_cnt + PRESC_W'(1);
         if (presc_tick) ts_cnt <= ts_cnt + TS_W'(1);
      end
   end

   assign ts_value = ts_cnt;

   // ==========================================
   // Timeout down-counter
   logic [15:0] to_cnt; // Cycles left
   assign to_hit = to_en && (to_cnt == '0); // [RQ13]

   // Reload on disable, on reaching zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) to_cnt <= TO_LIMIT_RST;
      else if (ce) begin
         if (!to_en || to_hit) to_cnt <= to_limit;
         else to_cnt <= to_cnt - 16'h0001;
      end
   end

   // ==========================================
   // Receive storage tracker
   cmf_rx_store u_rx (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .arb_next(rx_arb_next),
      .accept_ok(rx_accept_ok),
      .reject(rx_reject),
      .to_ded(rx_to_ded),
      .buf_idx(rx_buf_idx),
      .store_done(rx_store_done),
      .wr_fail(rx_wr_fail),
      .nd_clr(wr_newdata ? wdata[NBUF-1:0] : '0),
      .mrf_evt(rx_mrf_evt),
      .ded_evt(rx_ded_evt),
      .abort(rx_abort),
      .restart(rx_restart),
      .put_idx(rx_put_idx),
      .new_data(rx_new_data),
      .state(rx_state)
   );

   // ==========================================
   // Flag set and clear vectors
   assign fl.set[IDX_TEF_LOST] = tef_lost; // [RQ11] [RQ12]
   assign fl.set[IDX_TS_WRAP] = ts_wrap; // [RQ10]
   assign fl.set[IDX_MRF] = rx_mrf_evt | tx_mrf_evt; // [RQ2] [RQ4] [RQ7]
   assign fl.set[IDX_TIMEOUT] = to_hit; // [RQ13]
   assign fl.set[IDX_DED_RX] = rx_ded_evt; // [RQ1]
   assign fl.clr = wr_clear ? wdata[FLAG_LSB +: NFLAGS] : '0; // [RQ13]
   assign fl.en = int_en;

   // Sticky flag storage
   cmf_flag_bank u_flags (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .fi(fl)
   );

   assign irq = fl.irq;

   // ==========================================
   // Read mux; unmapped and write-only offsets read zero
   logic [DATA_W-1:0] rd_mux; // Selected word
   always_comb begin
      rd_mux = '0;
      if (hit(addr, OFS_STATUS)) rd_mux[FLAG_LSB +: NFLAGS] = fl.flags;
      else if (hit(addr, OFS_ENABLE)) rd_mux[FLAG_LSB +: NFLAGS] = int_en;
      else if (hit(addr, OFS_CONFIG)) begin
         rd_mux[CFG_RESTRICT] = restrict_q;
         rd_mux[CFG_TS_EN] = ts_en;
         rd_mux[CFG_TO_EN] = to_en;
         rd_mux[CFG_PRESC_LSB +: PRESC_W] = ts_presc;
      end
      else if (hit(addr, OFS_TS)) rd_mux[TS_W-1:0] = ts_cnt;
      else if (hit(addr, OFS_TO_LIMIT)) rd_mux[15:0] = to_limit;
      else if (hit(addr, OFS_RX_STATE)) begin
         rd_mux[PUT_W-1:0] = rx_put_idx;
         rd_mux[9:8] = rx_state;
      end
      else if (hit(addr, OFS_NEW_DATA)) rd_mux[NBUF-1:0] = rx_new_data;
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) rdata <= '0;
      else if (ce) rdata <= rd ? rd_mux : '0;
   end
endmodule : cmf_event_top

// File: testbench/cmf_event_chk.sv
// Port checker for the message RAM event flag block.
// Assumes it is bound to cmf_event_top on one clock.
`timescale 1ns/1ps
module cmf_event_chk
   import cmf_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [DATA_W-1:0] rdata,
   // Handlers
   input wire logic rx_arb_next,
   input wire logic rx_store_done,
   input wire logic rx_abort,
   input wire logic rx_restart,
   input wire logic [PUT_W-1:0] rx_put_idx,
   input wire logic [NBUF-1:0] rx_new_data,
   input wire logic tx_fetch_late,
   input wire logic tx_abort,
   // Status
   input wire logic restricted_operation_bit,
   input wire logic [TS_W-1:0] ts_value,
   input wire logic irq
);
   // ==========================================
   // Timing relations
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   a_tx_abort_now: assert property (tx_abort == tx_fetch_late)
      else $error("tx abort not tied to late fetch");
   a_tx_restrict_set: assert property (ce && tx_fetch_late |=> restricted_operation_bit)
      else $error("restricted mode not entered");
   a_restrict_leave_write: assert property ($fell(restricted_operation_bit) |->
      $past(wr && addr == OFS_CONFIG && !wdata[CFG_RESTRICT]))
      else $error("restricted mode left without host write");
   a_restart_is_late: assert property (rx_restart |-> rx_abort && rx_arb_next)
      else $error("restart without late abort");
   a_abort_keeps_put: assert property (rx_abort |=> $stable(rx_put_idx))
      else $error("put index moved after abort");
   a_abort_no_data: assert property (rx_abort |=>
      (rx_new_data & ~$past(rx_new_data)) == '0)
      else $error("new data set after abort");
   a_put_one_step: assert property ($changed(rx_put_idx) |->
      $past(rx_store_done) && rx_put_idx == PUT_W'($past(rx_put_idx) + 1))
      else $error("put index step wrong");
   a_new_data_cause: assert property (|(rx_new_data & ~$past(rx_new_data)) |->
      $past(rx_store_done))
      else $error("new data without store");
   a_ts_one_step: assert property ($changed(ts_value) |->
      ts_value == TS_W'($past(ts_value) + 1))
      else $error("timestamp step wrong");
   a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == '0)
      else $error("read data outside read cycle");
   // ==========================================
   // Scenario coverage
   c_restart: cover property (rx_restart);
   c_tx_abort: cover property (tx_abort);
   c_irq_rise: cover property ($rose(irq));
endmodule : cmf_event_chk

// File: testbench/cmf_event_top_bench.sv
// Self-checking bench for cmf_event_top.
// Assumes the package and design are compiled first.
`timescale 1ns/1ps
module cmf_event_top_bench;
   import cmf_pkg::*;
   // ==========================================
   // Stimulus and model state
   logic clk;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic tef_full = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] st = 8'h00; // Strobe bits: arb,acc,rej,ded,done,fail,txl,tef
   logic [31:0] wdata = 32'h0;
   logic [1:0] bi = 2'h0;
   logic [5:0] tef_size = 6'h08;
   logic [2:0] ab; // Sampled rx_abort, rx_restart, tx_abort
   wire [31:0] rdata;
   wire rxa, rxr, txa, rob, irq;
   wire [2:0] put;
   wire [3:0] nd;
   wire [15:0] ts;
   int failures = 0;
   int checks = 0;
   int seed = 32'hF24A2A79;
   int m_flags = 0; // Expected flags
   int m_en = 0;    // Expected enables
   int m_put = 0;   // Expected put index
   int m_nd = 0;    // Expected new-data bits
   cmf_event_top cmf_event_top_inst (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_arb_next(st[0]),
      .rx_accept_ok(st[1]), .rx_reject(st[2]), .rx_to_ded(st[3]), .rx_buf_idx(bi),
      .rx_store_done(st[4]), .rx_wr_fail(st[5]), .rx_abort(rxa), .rx_restart(rxr),
      .rx_put_idx(put), .rx_new_data(nd), .tx_fetch_late(st[6]), .tx_abort(txa),
      .tef_wr_try(st[7]), .tef_full(tef_full), .tef_size(tef_size),
      .restricted_operation_bit(rob), .ts_value(ts), .irq(irq));
   // Clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ==========================================
   // Tasks
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task rreg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rreg
   task pulse(input logic [7:0] v);
      @(posedge clk);
      st <= v;
      #1 ab = {rxa, rxr, txa};
      @(posedge clk);
      st <= 8'h00;
   endtask : pulse
   task cmp;
      logic [31:0] v;
      rreg(OFS_STATUS, v);
      chk("status", m_flags, v);
      chk("irq", 32'((m_flags & m_en) != 0), 32'(irq));
      chk("put", 32'(m_put), 32'(put));
      chk("new_data", 32'(m_nd), 32'(nd));
   endtask : cmp
   task clr;
      wreg(OFS_CLEAR, 32'h000F8000);
      m_flags = 0;
   endtask : clr
   task store(input logic ded, input logic [1:0] k, input logic fail);
      pulse(8'h01);
      bi <= k;
      pulse({4'h0, ded, 3'b010});
      pulse(fail ? 8'h20 : 8'h10);
      chk("abort", {2'b00, fail}, ab[2]);
      if (fail) m_flags |= 1 << 17;
      else if (ded) begin
         m_nd |= 1 << k;
         m_flags |= 1 << 19;
      end else m_put = (m_put + 1) % 8;
      cmp();
   endtask : store
   task report_and_stop;
      $display("Checks %0d, failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop
   // ==========================================
   // Main sequence
   initial begin
      logic [31:0] v;
      int k;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      for (k = 0; k < 9; k++) begin
         rreg(8'(4 * k), v);
         chk("reset reg", (8'(4 * k) == OFS_TO_LIMIT) ? 32'h0000FFFF : 32'h0, v);
      end
      v = $random(seed);
      wreg(OFS_ENABLE, v);
      m_en = v & 32'h000F8000;
      rreg(OFS_ENABLE, v);
      chk("enable", m_en, v);
      wreg(OFS_ENABLE, 32'h000F8000);
      m_en = 32'h000F8000;
      $display("Test registers done");
      for (k = 0; k < 4; k++) store(1'b1, k[1:0], 1'b0);
      store(1'b0, 2'h0, 1'b0);
      store(1'b0, 2'h0, 1'b1);
      store(1'b0, 2'h0, 1'b0);
      clr();
      wreg(OFS_NEW_DATA, 32'h5);
      m_nd &= ~5;
      cmp();
      $display("Test stores done");
      pulse(8'h01);
      pulse(8'h02);
      pulse(8'h01);
      chk("late", 32'h6, 32'(ab));
      m_flags |= 1 << 17;
      rreg(OFS_RX_STATE, v);
      chk("rx state", 32'h100 | m_put, v);
      pulse(8'h04);
      cmp();
      $display("Test late done");
      pulse(8'h40);
      chk("tx abort", 32'h1, 32'(ab));
      m_flags |= 1 << 17;
      #1 chk("restricted", 32'h1, 32'(rob));
      wreg(OFS_CONFIG, 32'h0);
      #1 chk("restricted", 32'h0, 32'(rob));
      cmp();
      clr();
      $display("Test transmit done");
      for (k = 0; k < 3; k++) begin
         tef_full <= (k == 0);
         tef_size <= (k == 1) ? 6'h00 : 6'h08;
         pulse(8'h80);
         if (k < 2) m_flags |= 1 << 15;
         cmp();
         clr();
      end
      $display("Test event fifo done");
      // Clock enable low: a zero-size write attempt must not set a flag
      ce <= 1'b0;
      tef_size <= 6'h00;
      pulse(8'h80);
      ce <= 1'b1;
      tef_size <= 6'h08;
      cmp();
      $display("Test enable done");
      wreg(OFS_TO_LIMIT, 32'h5);
      wreg(OFS_CONFIG, 32'h4);
      repeat (10) @(posedge clk);
      wreg(OFS_CONFIG, 32'h0);
      m_flags |= 1 << 18;
      cmp();
      repeat (20) @(posedge clk);
      cmp();
      clr();
      cmp();
      $display("Test timeout done");
      wreg(OFS_CONFIG, 32'h2);
      k = 0;
      while (ts !== 16'hFFFF && k < 70000) begin
         @(posedge clk);
         k++;
      end
      repeat (2) @(posedge clk);
      wreg(OFS_CONFIG, 32'h0);
      m_flags |= 1 << 16;
      cmp();
      // Prescale 3: one count every four cycles
      wreg(OFS_CONFIG, 32'h32);
      k = ts;
      repeat (16) @(posedge clk);
      #1 chk("ts prescale", 32'(k + 4), 32'(ts));
      $display("Test timestamp done");
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      {m_flags, m_en, m_put, m_nd} = '0;
      cmp();
      $display("Test second reset done");
      report_and_stop();
   end
   // Watchdog against a hang
   initial begin
      repeat (100000) @(posedge clk);
      failures++;
      report_and_stop();
   end
endmodule : cmf_event_top_bench

bind cmf_event_top cmf_event_chk cmf_event_chk_inst (.clk(clk), .rstn(rstn), .ce(ce),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .rx_arb_next(rx_arb_next), .rx_store_done(rx_store_done), .rx_abort(rx_abort),
   .rx_restart(rx_restart), .rx_put_idx(rx_put_idx), .rx_new_data(rx_new_data),
   .tx_fetch_late(tx_fetch_late), .tx_abort(tx_abort),
   .restricted_operation_bit(restricted_operation_bit), .ts_value(ts_value), .irq(irq));
